// [hw/irat_cfg.svh]
// constants of the interleave register address translator
`ifndef IRAT_CFG_SVH
`define IRAT_CFG_SVH
`define IRAT_LINE_BYTES     16'h0100
`define IRAT_LINE_SHIFT     8
`define IRAT_NMOD           4
`define IRAT_MOD_W          2
`define IRAT_NLINE          16
`define IRAT_LINE_W         4
`define IRAT_PIPE_LAT       3
`define IRAT_CMD_ADDR_MSB   36
`define IRAT_CMD_SIZE_LSB   48
`define IRAT_CMD_SIZE_MSB   55
`define IRAT_CMD_DIR_BIT    56
`define IRAT_DPA_SHIFT      6
`define IRAT_RST_LINES      8'h01
`define IRAT_RST_WAYS       8'h01
`define IRAT_RST_CTRLS      8'h01
`endif

// [hw/irat_pkg.sv]
// types of the interleave register address translator
package irat_pkg;
   // register kind addressed by one request
   typedef enum logic [1:0] {
      IRAT_KIND_CMD    = 2'b00,
      IRAT_KIND_STATUS = 2'b01,
      IRAT_KIND_APER   = 2'b10,
      IRAT_KIND_PMEM   = 2'b11
   } irat_kind_type;
   // per-module configuration field selected by the load port
   typedef enum logic [3:0] {
      IRAT_FLD_LINES     = 4'h0,
      IRAT_FLD_WAYS      = 4'h1,
      IRAT_FLD_CTRLS     = 4'h2,
      IRAT_FLD_IL_ON     = 4'h3,
      IRAT_FLD_CTRL_BASE = 4'h4,
      IRAT_FLD_APER_BASE = 4'h5,
      IRAT_FLD_PMEM_BASE = 4'h6,
      IRAT_FLD_CMD_START = 4'h7,
      IRAT_FLD_CMD_SIZE  = 4'h8,
      IRAT_FLD_ST_START  = 4'h9,
      IRAT_FLD_ST_SIZE   = 4'ha,
      IRAT_FLD_AP_START  = 4'hb,
      IRAT_FLD_AP_SIZE   = 4'hc,
      IRAT_FLD_DISP      = 4'hd
   } irat_field_type;
   // request sequencer state
   typedef enum logic [0:0] {
      IRAT_ST_IDLE = 1'b0,
      IRAT_ST_WALK = 1'b1
   } irat_state_type;
endpackage

// [hw/irat_translator.sv]
// host-side translator from block-window register offsets to host physical locations
// Behaviour
// - rotation bytes = line bytes times lines
// - line index = (offset mod rotation)/line bytes
// - rotation index = offset / rotation bytes
// - remainder = offset mod 256, added unchanged
// - displacement fetched from module table at index
// - interleaved address formula with region base
// - no interleave: offset plus region base
// - width = ways per controller times controllers
// - control base type 2, aperture base type 3
// - persistent range type 1 bypasses interleave
// - line bytes per request, lines per repeat
// - per-kind start offset and size per module
// - always use the targeted module's own set
// - all accesses translated, aperture per line step
`timescale 1ns/100ps
`include "irat_cfg.svh"
module irat_translator
   import irat_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // configuration load port
   input  wire logic                 cfg_we,
   input  wire logic [1:0]           cfg_module,
   input  wire irat_pkg::irat_field_type cfg_field,
   input  wire logic [3:0]           cfg_index,
   input  wire logic [63:0]          cfg_data,
   // translation request
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire logic [1:0]           req_module,
   input  wire irat_pkg::irat_kind_type req_kind,
   input  wire logic [7:0]           req_window,
   input  wire logic [31:0]          req_byte_offset,
   input  wire logic [7:0]           req_lines,
   input  wire logic [42:0]          req_dpa,
   input  wire logic                 req_write,
   input  wire logic [7:0]           req_xfer_lines,
   // translated answer
   output logic                      out_valid,
   output logic [63:0]               out_address,
   output irat_pkg::irat_kind_type   out_kind,
   output logic                      out_last,
   output logic [63:0]               out_cmd_word
);
   import irat_pkg::*;

   // per-module interleave tables
   logic [7:0]  lines_tbl   [`IRAT_NMOD];   // lines per rotation
   logic [7:0]  ways_tbl    [`IRAT_NMOD];   // modules per controller
   logic [7:0]  ctrls_tbl   [`IRAT_NMOD];   // controllers in the set
   logic        il_tbl      [`IRAT_NMOD];   // interleave present
   logic [63:0] cbase_tbl   [`IRAT_NMOD];   // control region base
   logic [63:0] abase_tbl   [`IRAT_NMOD];   // aperture region base
   logic [63:0] pbase_tbl   [`IRAT_NMOD];   // persistent range base
   logic [31:0] cstart_tbl  [`IRAT_NMOD];   // command start offset
   logic [31:0] csize_tbl   [`IRAT_NMOD];   // command register size
   logic [31:0] sstart_tbl  [`IRAT_NMOD];   // status start offset
   logic [31:0] ssize_tbl   [`IRAT_NMOD];   // status register size
   logic [31:0] astart_tbl  [`IRAT_NMOD];   // aperture start offset
   logic [31:0] asize_tbl   [`IRAT_NMOD];   // aperture size
   logic [63:0] disp_tbl    [`IRAT_NMOD*`IRAT_NLINE]; // per-line displacement

   // sequencer and pipeline state
   irat_state_type  state_r;
   irat_state_type  state_nxt;
   logic [1:0]      seq_mod_r;       // module of the burst
   irat_kind_type   seq_kind_r;      // kind of the burst
   logic [31:0]     seq_off_r;       // next offset in the burst
   logic [7:0]      seq_left_r;      // lines still to issue
   logic            s0_valid_r;      // stage 0 holds an offset
   logic            s0_first_r;      // stage 0 is a burst head
   logic [1:0]      s0_mod_r;
   irat_kind_type   s0_kind_r;
   logic [31:0]     s0_off_r;
   logic            s0_last_r;
   logic            s1_valid_r;      // stage 1 holds split terms
   logic [1:0]      s1_mod_r;
   irat_kind_type   s1_kind_r;
   logic [31:0]     s1_off_r;
   logic [15:0]     s1_rot_r;        // rotation bytes
   logic [31:0]     s1_ri_r;         // rotation index
   logic [7:0]      s1_li_r;         // line index
   logic [7:0]      s1_rem_r;        // remainder in the line
   logic [15:0]     s1_width_r;      // interleave width
   logic [63:0]     s1_base_r;       // region base
   logic            s1_il_r;         // interleave correction applies
   logic            s1_last_r;
   logic            out_valid_r;
   logic [63:0]     out_address_r;
   irat_kind_type   out_kind_r;
   logic            out_last_r;
   logic [63:0]     cmd_word_r;

   // offset of one register inside its module's window
   function automatic logic [31:0] reg_offset(input irat_kind_type k, input logic [31:0] start,
                                              input logic [31:0] size, input logic [7:0] win,
                                              input logic [31:0] byte_off);
      logic [31:0] span;
      span = 32'(size * {24'h000000, win});
      reg_offset = (k == IRAT_KIND_PMEM) ? byte_off : 32'(start + span + byte_off);
   endfunction

   // rotation bytes, kept nonzero so the divider is always defined
   function automatic logic [15:0] rot_bytes(input logic [7:0] lines);
      logic [15:0] r;
      r = 16'({8'h00, lines} << `IRAT_LINE_SHIFT);
      rot_bytes = (r == 16'h0000) ? `IRAT_LINE_BYTES : r;
   endfunction

   // decode of the incoming request
   wire logic        accept    = req_valid && req_ready;
   wire logic        walk_go   = (state_r == IRAT_ST_WALK);
   wire logic [31:0] start_sel = (req_kind == IRAT_KIND_CMD)    ? cstart_tbl[req_module] :
                                 (req_kind == IRAT_KIND_STATUS) ? sstart_tbl[req_module] :
                                 astart_tbl[req_module];
   wire logic [31:0] size_sel  = (req_kind == IRAT_KIND_CMD)    ? csize_tbl[req_module] :
                                 (req_kind == IRAT_KIND_STATUS) ? ssize_tbl[req_module] :
                                 asize_tbl[req_module];
   wire logic [31:0] head_off  = reg_offset(req_kind, start_sel, size_sel, req_window, req_byte_offset);
   // only aperture bursts walk several lines
   wire logic [7:0]  head_cnt  = (req_kind == IRAT_KIND_APER && req_lines > 8'h01) ? req_lines : 8'h01;
   wire logic [31:0] line_step = {16'h0000, `IRAT_LINE_BYTES};
   assign req_ready = (state_r == IRAT_ST_IDLE);

   // stage 1 arithmetic on the stage 0 offset, using only that module's set
   wire logic [15:0] rot_w    = rot_bytes(lines_tbl[s0_mod_r]);
   wire logic [31:0] rot32_w  = {16'h0000, rot_w};
   wire logic [31:0] ri_w     = s0_off_r / rot32_w;
   wire logic [31:0] inrot_w  = s0_off_r % rot32_w;
   wire logic [7:0]  li_w     = 8'(inrot_w >> `IRAT_LINE_SHIFT);
   wire logic [7:0]  rem_w    = s0_off_r[7:0];
   wire logic [15:0] width_w  = 16'(ways_tbl[s0_mod_r] * ctrls_tbl[s0_mod_r]);
   wire logic [63:0] base_w   = (s0_kind_r == IRAT_KIND_PMEM) ? pbase_tbl[s0_mod_r] :
                                (s0_kind_r == IRAT_KIND_APER) ? abase_tbl[s0_mod_r] :
                                cbase_tbl[s0_mod_r];
   wire logic        il_w     = il_tbl[s0_mod_r] && (s0_kind_r != IRAT_KIND_PMEM);

   // stage 2 sum
   wire logic [63:0] disp_w   = disp_tbl[{s1_mod_r, s1_li_r[`IRAT_LINE_W-1:0]}];
   wire logic [63:0] stride_w = 64'({48'h0, s1_rot_r} * {32'h0, s1_ri_r} * {48'h0, s1_width_r});
   wire logic [63:0] il_addr  = 64'(stride_w + disp_w + {56'h0, s1_rem_r} + s1_base_r);
   wire logic [63:0] flat_addr = 64'({32'h0, s1_off_r} + s1_base_r);

   // command word for the window command register
   wire logic [63:0] cmd_w = {7'h00, req_write, req_xfer_lines, 11'h000,
                              req_dpa[42:`IRAT_DPA_SHIFT]};

   // configuration tables load
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int m = 0; m < `IRAT_NMOD; m++) begin
            lines_tbl[m]  <= `IRAT_RST_LINES;
            ways_tbl[m]   <= `IRAT_RST_WAYS;
            ctrls_tbl[m]  <= `IRAT_RST_CTRLS;
            il_tbl[m]     <= 1'b0;
            cbase_tbl[m]  <= 64'h0;
            abase_tbl[m]  <= 64'h0;
            pbase_tbl[m]  <= 64'h0;
            cstart_tbl[m] <= 32'h0;
            csize_tbl[m]  <= 32'h0;
            sstart_tbl[m] <= 32'h0;
            ssize_tbl[m]  <= 32'h0;
            astart_tbl[m] <= 32'h0;
            asize_tbl[m]  <= 32'h0;
         end
         for (int d = 0; d < `IRAT_NMOD*`IRAT_NLINE; d++) begin
            disp_tbl[d] <= 64'h0;
         end
      end else if (cfg_we) begin
         case (cfg_field)
            IRAT_FLD_LINES:     lines_tbl[cfg_module]  <= cfg_data[7:0];
            IRAT_FLD_WAYS:      ways_tbl[cfg_module]   <= cfg_data[7:0];
            IRAT_FLD_CTRLS:     ctrls_tbl[cfg_module]  <= cfg_data[7:0];
            IRAT_FLD_IL_ON:     il_tbl[cfg_module]     <= cfg_data[0];
            IRAT_FLD_CTRL_BASE: cbase_tbl[cfg_module]  <= cfg_data;
            IRAT_FLD_APER_BASE: abase_tbl[cfg_module]  <= cfg_data;
            IRAT_FLD_PMEM_BASE: pbase_tbl[cfg_module]  <= cfg_data;
            IRAT_FLD_CMD_START: cstart_tbl[cfg_module] <= cfg_data[31:0];
            IRAT_FLD_CMD_SIZE:  csize_tbl[cfg_module]  <= cfg_data[31:0];
            IRAT_FLD_ST_START:  sstart_tbl[cfg_module] <= cfg_data[31:0];
            IRAT_FLD_ST_SIZE:   ssize_tbl[cfg_module]  <= cfg_data[31:0];
            IRAT_FLD_AP_START:  astart_tbl[cfg_module] <= cfg_data[31:0];
            IRAT_FLD_AP_SIZE:   asize_tbl[cfg_module]  <= cfg_data[31:0];
            IRAT_FLD_DISP:      disp_tbl[{cfg_module, cfg_index}] <= cfg_data;
            default: begin
               // unused field codes are ignored
            end
         endcase
      end
   end

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         IRAT_ST_IDLE: begin
            if (accept && head_cnt > 8'h01) begin
               state_nxt = IRAT_ST_WALK;
            end
         end
         IRAT_ST_WALK: begin
            if (seq_left_r == 8'h01) begin
               state_nxt = IRAT_ST_IDLE;
            end
         end
         default: state_nxt = IRAT_ST_IDLE;
      endcase
   end

   // sequencer registers: one aperture line offset per cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r    <= IRAT_ST_IDLE;
         seq_mod_r  <= 2'h0;
         seq_kind_r <= IRAT_KIND_CMD;
         seq_off_r  <= 32'h0;
         seq_left_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         if (accept) begin
            seq_mod_r  <= req_module;
            seq_kind_r <= req_kind;
            seq_off_r  <= 32'(head_off + line_step);
            seq_left_r <= 8'(head_cnt - 8'h01);
         end else if (walk_go) begin
            seq_off_r  <= 32'(seq_off_r + line_step);
            seq_left_r <= 8'(seq_left_r - 8'h01);
         end
      end
   end

   // stage 0: offset to translate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s0_valid_r <= 1'b0;
         s0_first_r <= 1'b0;
         s0_mod_r   <= 2'h0;
         s0_kind_r  <= IRAT_KIND_CMD;
         s0_off_r   <= 32'h0;
         s0_last_r  <= 1'b0;
      end else begin
         s0_valid_r <= accept || walk_go;
         s0_first_r <= accept;
         s0_mod_r   <= accept ? req_module : seq_mod_r;
         s0_kind_r  <= accept ? req_kind : seq_kind_r;
         s0_off_r   <= accept ? head_off : seq_off_r;
         s0_last_r  <= accept ? (head_cnt == 8'h01) : (seq_left_r == 8'h01);
      end
   end

   // stage 1: split offset into rotation, line and remainder
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_valid_r <= 1'b0;
         s1_mod_r   <= 2'h0;
         s1_kind_r  <= IRAT_KIND_CMD;
         s1_off_r   <= 32'h0;
         s1_rot_r   <= 16'h0;
         s1_ri_r    <= 32'h0;
         s1_li_r    <= 8'h0;
         s1_rem_r   <= 8'h0;
         s1_width_r <= 16'h0;
         s1_base_r  <= 64'h0;
         s1_il_r    <= 1'b0;
         s1_last_r  <= 1'b0;
      end else begin
         s1_valid_r <= s0_valid_r;
         s1_mod_r   <= s0_mod_r;
         s1_kind_r  <= s0_kind_r;
         s1_off_r   <= s0_off_r;
         s1_rot_r   <= rot_w;
         s1_ri_r    <= ri_w;
         s1_li_r    <= li_w;
         s1_rem_r   <= rem_w;
         s1_width_r <= width_w;
         s1_base_r  <= base_w;
         s1_il_r    <= il_w;
         s1_last_r  <= s0_last_r;
      end
   end

   // stage 2: final address; command word loaded on the accepting edge, two cycles ahead of it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_valid_r   <= 1'b0;
         out_address_r <= 64'h0;
         out_kind_r    <= IRAT_KIND_CMD;
         out_last_r    <= 1'b0;
         cmd_word_r    <= 64'h0;
      end else begin
         out_valid_r   <= s1_valid_r;
         out_address_r <= s1_il_r ? il_addr : flat_addr;
         out_kind_r    <= s1_kind_r;
         out_last_r    <= s1_last_r;
         if (accept && req_kind == IRAT_KIND_CMD) begin
            cmd_word_r <= cmd_w;
         end
      end
   end

   // outputs from flip-flops
   assign out_valid    = out_valid_r;
   assign out_address  = out_address_r;
   assign out_kind     = out_kind_r;
   assign out_last     = out_last_r;
   assign out_cmd_word = cmd_word_r;

   // checks
   a_rot_bytes: assert property (@(posedge clk) disable iff (!reset_n)
      s0_valid_r |=> s1_rot_r == rot_bytes(lines_tbl[$past(s0_mod_r)]))
      else $error("rotation bytes wrong");
   a_line_index: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r |-> s1_li_r == 8'(((s1_off_r % {16'h0, s1_rot_r})) >> 8))
      else $error("line index wrong");
   a_rot_index: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r |-> s1_ri_r == s1_off_r / {16'h0, s1_rot_r})
      else $error("rotation index wrong");
   a_remainder_low: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r |-> s1_rem_r == s1_off_r[7:0])
      else $error("remainder wrong");
   a_il_address: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r && s1_il_r |=> out_valid && out_address == 64'($past(stride_w) + $past(disp_w)
         + {56'h0, $past(s1_rem_r)} + $past(s1_base_r)))
      else $error("interleaved address wrong");
   a_flat_address: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r && !s1_il_r |=> out_address == 64'({32'h0, $past(s1_off_r)} + $past(s1_base_r)))
      else $error("flat address wrong");
   a_width_prod: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r |-> s1_width_r == 16'(ways_tbl[s1_mod_r] * ctrls_tbl[s1_mod_r]))
      else $error("interleave width wrong");
   a_pmem_bypass: assert property (@(posedge clk) disable iff (!reset_n)
      s1_valid_r && s1_kind_r == IRAT_KIND_PMEM |-> !s1_il_r && s1_base_r == pbase_tbl[s1_mod_r])
      else $error("persistent range not bypassed");
   a_burst_step: assert property (@(posedge clk) disable iff (!reset_n)
      s0_valid_r && !s0_first_r |-> s0_off_r == 32'($past(s0_off_r) + 32'h100))
      else $error("aperture step wrong");
   a_fixed_latency: assert property (@(posedge clk) disable iff (!reset_n)
      accept |-> ##3 out_valid)
      else $error("latency wrong");
   a_cmd_dir: assert property (@(posedge clk) disable iff (!reset_n)
      accept && req_kind == IRAT_KIND_CMD |=> out_cmd_word[56] == $past(req_write)
         && out_cmd_word[55:48] == $past(req_xfer_lines))
      else $error("command word wrong");
endmodule

// [verif/irat_translator_tb.sv]
// self-checking bench of the interleave register address translator
`timescale 1ns/100ps
module irat_translator_tb;
   import irat_pkg::*;
   // stimulus and observed signals
   logic                 clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 cfg_we = 1'b0;
   logic [1:0]           cfg_module = 2'h0;
   irat_field_type       cfg_field = IRAT_FLD_LINES;
   logic [3:0]           cfg_index = 4'h0;
   logic [63:0]          cfg_data = 64'h0;
   logic                 req_valid = 1'b0;
   logic                 req_ready;
   logic [1:0]           req_module = 2'h0;
   irat_kind_type        req_kind = IRAT_KIND_CMD;
   logic [7:0]           req_window = 8'h00;
   logic [31:0]          req_byte_offset = 32'h0;
   logic [7:0]           req_lines = 8'h00;
   logic [42:0]          req_dpa = 43'h0;
   logic                 req_write = 1'b0;
   logic [7:0]           req_xfer_lines = 8'h00;
   logic                 out_valid;
   logic [63:0]          out_address;
   irat_kind_type        out_kind;
   logic                 out_last;
   logic [63:0]          out_cmd_word;
   logic [63:0]          dev_cmd_word;
   logic [63:0]          dev_cmd_addr;
   logic [7:0]           dev_status;
   logic [7:0]           dev_status_seen;
   int                   err_count = 0;
   int                   checks = 0;
   // module 1 interleave set: two lines, two ways on three controllers
   logic [63:0]          disp_tab [0:15];
   localparam logic [63:0] CBASE = 64'h0000_0001_0000_0000;
   localparam logic [63:0] ABASE = 64'h0000_0002_0000_0000;
   localparam logic [63:0] PBASE = 64'h0000_0003_0000_0000;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   irat_translator irat_translator_i (.clk(clk), .reset_n(reset_n), .cfg_we(cfg_we), .cfg_module(cfg_module),
      .cfg_field(cfg_field), .cfg_index(cfg_index), .cfg_data(cfg_data), .req_valid(req_valid),
      .req_ready(req_ready), .req_module(req_module), .req_kind(req_kind), .req_window(req_window),
      .req_byte_offset(req_byte_offset), .req_lines(req_lines), .req_dpa(req_dpa), .req_write(req_write),
      .req_xfer_lines(req_xfer_lines), .out_valid(out_valid), .out_address(out_address),
      .out_kind(out_kind), .out_last(out_last), .out_cmd_word(out_cmd_word));

   irat_window_device irat_window_device_i (.clk(clk), .reset_n(reset_n), .out_valid(out_valid),
      .out_address(out_address), .out_kind(out_kind), .out_cmd_word(out_cmd_word),
      .cmd_word_r(dev_cmd_word), .cmd_addr_r(dev_cmd_addr), .status_r(dev_status),
      .status_seen_r(dev_status_seen));

   // compare one value and report a mismatch
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // interleaved address of module 1 for a register offset
   function automatic logic [63:0] il_addr(input logic [63:0] off, input logic [63:0] base);
      logic [63:0] rot;
      rot = 64'd512;
      return (off / rot) * rot * 64'd6 + disp_tab[(off % rot) / 64'd256] + {56'h0, off[7:0]} + base;
   endfunction

   // load one configuration word
   task automatic cfg(input logic [1:0] m, input irat_field_type f, input logic [3:0] i, input logic [63:0] d);
      @(negedge clk);
      cfg_we     = 1'b1;
      cfg_module = m;
      cfg_field  = f;
      cfg_index  = i;
      cfg_data   = d;
      @(negedge clk);
      cfg_we = 1'b0;
   endtask

   // issue one request and judge each translated address of it
   task automatic do_req(input logic [1:0] m, input irat_kind_type k, input logic [7:0] win,
                         input logic [31:0] boff, input int n, input bit il, input logic [63:0] off0,
                         input logic [63:0] base);
      logic [63:0] off;
      @(negedge clk);
      chk({63'h0, req_ready}, 64'h1, "ready idle");
      req_valid       = 1'b1;
      req_module      = m;
      req_kind        = k;
      req_window      = win;
      req_byte_offset = boff;
      req_lines       = n[7:0];
      @(negedge clk);
      req_valid = 1'b0;
      if (n > 1) chk({63'h0, req_ready}, 64'h0, "ready in burst");
      // the first address stands in the third cycle after the take
      repeat (1) @(negedge clk);
      for (int j = 0; j < n; j++) begin
         @(negedge clk);
         off = off0 + 64'd256 * j;
         chk({63'h0, out_valid}, 64'h1, "valid");
         chk(out_address, il ? il_addr(off, base) : off + base, "address");
         chk({62'h0, out_kind}, {62'h0, k}, "kind");
         chk({63'h0, out_last}, {63'h0, j == n - 1}, "last");
      end
      @(negedge clk);
      chk({63'h0, out_valid}, 64'h0, "valid drop");
   endtask

   // interleaved command write with command word on module 1
   task automatic t_il_cmd();
      req_dpa        = 43'h512_3456_7840;
      req_write      = 1'b1;
      req_xfer_lines = 8'h40;
      do_req(2'd1, IRAT_KIND_CMD, 8'd3, 32'h10, 1, 1'b1, 64'h10d0, CBASE);
      chk(out_cmd_word, {7'h0, 1'b1, 8'h40, 11'h0, req_dpa[42:6]}, "cmd word");
      chk(dev_cmd_word, {7'h0, 1'b1, 8'h40, 11'h0, req_dpa[42:6]}, "device cmd");
      chk(dev_cmd_addr, il_addr(64'h10d0, CBASE), "device cmd addr");
   endtask

   // aperture burst over both lines, then status read and its clearing
   task automatic t_aper_status();
      do_req(2'd1, IRAT_KIND_APER, 8'd0, 32'h100, 3, 1'b1, 64'h8100, ABASE);
      do_req(2'd1, IRAT_KIND_STATUS, 8'd1, 32'h0, 1, 1'b1, 64'h2040, CBASE);
      chk({56'h0, dev_status_seen}, 64'h3, "status lines");
      do_req(2'd1, IRAT_KIND_STATUS, 8'd1, 32'h0, 1, 1'b1, 64'h2040, CBASE);
      chk({56'h0, dev_status_seen}, 64'h0, "status cleared");
   endtask

   // bypass, plain and per-module cases
   task automatic t_bypass();
      do_req(2'd1, IRAT_KIND_PMEM, 8'd5, 32'h1234, 1, 1'b0, 64'h1234, PBASE);
      // read direction command with a different transfer size
      req_write      = 1'b0;
      req_xfer_lines = 8'h10;
      do_req(2'd0, IRAT_KIND_CMD, 8'd2, 32'h8, 1, 1'b0, 64'h1088, 64'h4000_0000);
      chk(out_cmd_word, {7'h0, 1'b0, 8'h10, 11'h0, req_dpa[42:6]}, "read cmd word");
      chk(dev_cmd_word, {7'h0, 1'b0, 8'h10, 11'h0, req_dpa[42:6]}, "device read cmd");
      do_req(2'd2, IRAT_KIND_CMD, 8'd0, 32'h12, 1, 1'b0, 64'h12, 64'h700);
   endtask

   // report and end the run
   task automatic wrap_up();
      $display("checks %0d, errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      #20000;
      err_count++;
      wrap_up();
   end

   // main sequence
   initial begin
      for (int i = 0; i < 16; i++) disp_tab[i] = 64'h0;
      disp_tab[0] = 64'h100;
      disp_tab[1] = 64'h300;
      repeat (6) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      cfg(2'd1, IRAT_FLD_LINES, 4'h0, 64'h2);
      cfg(2'd1, IRAT_FLD_WAYS, 4'h0, 64'h2);
      cfg(2'd1, IRAT_FLD_CTRLS, 4'h0, 64'h3);
      cfg(2'd1, IRAT_FLD_IL_ON, 4'h0, 64'h1);
      cfg(2'd1, IRAT_FLD_CTRL_BASE, 4'h0, CBASE);
      cfg(2'd1, IRAT_FLD_APER_BASE, 4'h0, ABASE);
      cfg(2'd1, IRAT_FLD_PMEM_BASE, 4'h0, PBASE);
      cfg(2'd1, IRAT_FLD_CMD_START, 4'h0, 64'h1000);
      cfg(2'd1, IRAT_FLD_CMD_SIZE, 4'h0, 64'h40);
      cfg(2'd1, IRAT_FLD_ST_START, 4'h0, 64'h2000);
      cfg(2'd1, IRAT_FLD_ST_SIZE, 4'h0, 64'h40);
      cfg(2'd1, IRAT_FLD_AP_START, 4'h0, 64'h8000);
      cfg(2'd1, IRAT_FLD_AP_SIZE, 4'h0, 64'h2000);
      cfg(2'd1, IRAT_FLD_DISP, 4'h0, 64'h100);
      cfg(2'd1, IRAT_FLD_DISP, 4'h1, 64'h300);
      cfg(2'd0, IRAT_FLD_CTRL_BASE, 4'h0, 64'h4000_0000);
      cfg(2'd0, IRAT_FLD_CMD_START, 4'h0, 64'h1000);
      cfg(2'd0, IRAT_FLD_CMD_SIZE, 4'h0, 64'h40);
      cfg(2'd2, IRAT_FLD_IL_ON, 4'h0, 64'h1);
      cfg(2'd2, IRAT_FLD_DISP, 4'h0, 64'h700);
      t_il_cmd();
      t_aper_status();
      t_bypass();
      wrap_up();
   end
endmodule

// [verif/irat_window_device.sv]
// behavioural block-window register device reached through translated addresses
`timescale 1ns/100ps
module irat_window_device
   import irat_pkg::*;
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // translated accesses
   input  wire logic                    out_valid,
   input  wire logic [63:0]             out_address,
   input  wire irat_pkg::irat_kind_type out_kind,
   input  wire logic [63:0]             out_cmd_word,
   // register views for the bench
   output logic [63:0]                  cmd_word_r,
   output logic [63:0]                  cmd_addr_r,
   output logic [7:0]                   status_r,
   output logic [7:0]                   status_seen_r
);
   // latch commands, count aperture lines, clear status when it is read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_word_r    <= 64'h0;
         cmd_addr_r    <= 64'h0;
         status_r      <= 8'h00;
         status_seen_r <= 8'h00;
      end else if (out_valid) begin
         case (out_kind)
            // a new command restarts the window
            IRAT_KIND_CMD: begin
               cmd_word_r <= out_cmd_word;
               cmd_addr_r <= out_address;
               status_r   <= 8'h00;
            end
            // host read returns status and the device clears it
            IRAT_KIND_STATUS: begin
               status_seen_r <= status_r;
               status_r      <= 8'h00;
            end
            // each aperture line moved is counted
            IRAT_KIND_APER: status_r <= status_r + 8'h01;
            default: ;
         endcase
      end
   end
endmodule
